// ==== rtl/cgi_pkg.sv ====
// Shared constants for the two-wire register port and its master.
package cgi_pkg;
   localparam logic [5:0] DEV_ADDR_HI = 6'h13;
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] BIT_MSB = 3'h7;
   localparam logic [3:0] NIBBLE_ONE = 4'h1;
   localparam logic ACK_LEVEL = 1'b0;
   localparam logic NACK_LEVEL = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   localparam int CLK_HZ = 20000000;
   localparam int SCL_HZ = 100000;
   localparam int SCL_QTR_CYC = CLK_HZ / (4 * SCL_HZ);
   localparam int REG_COUNT = 256;
endpackage

// ==== rtl/cgi_link_if.sv ====
// Two-wire link between the master end and the register port end.
`timescale 1ns/1ps
interface cgi_link_if;
   logic scl_o;
   logic scl_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_s_o;
   logic sda_s_oe_n;
   logic scl;
   logic sda;
   // Open-drain wires with pull-ups: low wins when any driver is enabled.
   assign scl = (!scl_oe_n && !scl_o) ? 1'b0 : 1'b1;
   assign sda = ((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o)) ? 1'b0 : 1'b1;
   modport master (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n, input scl, input sda);
   modport slave (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface

// ==== rtl/cgi_slave.sv ====
// Register port end: two-wire slave holding the byte-wide register array.
//
// Behaviour
// - Bytes shift most significant bit first.
// - Answer address 010011X, X from select pin.
// - Acknowledge drives data low on ninth clock.
// - Master opens each transaction with start.
// - Single write: address, index, data, all acknowledged.
// - Single read via repeated start, final byte unacknowledged.
// - Multi write: further data bytes, each acknowledged.
// - Multi read: master acknowledges all but last.
// - Increment only lower index nibble per byte.
// - Upper index nibble never advances automatically.
// - Master splits map into sixteen index groups.
`timescale 1ns/1ps
module cgi_slave #(
   parameter int DEPTH = cgi_pkg::REG_COUNT
) (
   input wire logic clk,
   input wire logic rstn,
   cgi_link_if.slave link,
   input wire logic address_select_pin,
   output logic wr_strobe,
   output logic [7:0] wr_index,
   output logic [7:0] wr_data,
   output logic [7:0] cur_index,
   output logic busy
);
   typedef enum logic [2:0] {
      CGI_IDLE = 3'b000,
      CGI_ADDR = 3'b001,
      CGI_INDEX = 3'b011,
      CGI_WDATA = 3'b010,
      CGI_RDATA = 3'b110,
      CGI_SKIP = 3'b111
   } cgi_state_e;

   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   cgi_state_e state_q;
   logic [2:0] bit_q;
   logic ack_phase_q;
   logic [7:0] shift_q;
   logic [7:0] index_q;
   logic [7:0] tx_q;
   logic ack_drive_q;
   logic tx_drive_q;
   logic master_ack_q;
   logic skip_fall_q;
   logic [1:0] sel_sync_q;
   logic [7:0] mem [DEPTH];

   function automatic logic [7:0] next_index(input logic [7:0] idx);
      next_index = {idx[7:4], idx[3:0] + cgi_pkg::NIBBLE_ONE};
   endfunction

   // Two-stage synchronisers; only the second stage feeds the edge logic.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         sel_sync_q <= 2'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], link.scl};
         sda_sync_q <= {sda_sync_q[0], link.sda};
         sel_sync_q <= {sel_sync_q[0], address_select_pin};
         scl_q <= scl_sync_q[1];
         sda_q <= sda_sync_q[1];
      end
   end

   assign scl_rise = scl_sync_q[1] && !scl_q;
   assign scl_fall = !scl_sync_q[1] && scl_q;
   assign start_seen = scl_sync_q[1] && scl_q && sda_q && !sda_sync_q[1];
   assign stop_seen = scl_sync_q[1] && scl_q && !sda_q && sda_sync_q[1];

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= CGI_IDLE;
         bit_q <= cgi_pkg::BIT_MSB;
         ack_phase_q <= 1'b0;
         shift_q <= 8'h00;
         index_q <= 8'h00;
         ack_drive_q <= 1'b0;
         tx_drive_q <= 1'b0;
         tx_q <= 8'h00;
         master_ack_q <= 1'b0;
         skip_fall_q <= 1'b0;
         wr_strobe <= 1'b0;
         wr_index <= 8'h00;
         wr_data <= 8'h00;
      end
      else
      begin
         wr_strobe <= 1'b0;
         if (start_seen)
         begin
            state_q <= CGI_ADDR;
            skip_fall_q <= 1'b1;
            bit_q <= cgi_pkg::BIT_MSB;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            tx_drive_q <= 1'b0;
         end
         else if (stop_seen)
         begin
            state_q <= CGI_IDLE;
            ack_drive_q <= 1'b0;
            tx_drive_q <= 1'b0;
         end
         else if (scl_rise && !ack_phase_q && state_q != CGI_IDLE && state_q != CGI_SKIP)
         begin
            shift_q <= {shift_q[6:0], sda_q};
         end
         else if (scl_rise && ack_phase_q && state_q == CGI_RDATA)
         begin
            master_ack_q <= (sda_q == cgi_pkg::ACK_LEVEL);
         end
         else if (scl_fall && skip_fall_q)
         begin
            // The clock fall that completes a start carries no data bit.
            skip_fall_q <= 1'b0;
         end
         else if (scl_fall && !ack_phase_q && state_q != CGI_IDLE && state_q != CGI_SKIP)
         begin
            if (state_q == CGI_RDATA)
               tx_q <= {tx_q[6:0], 1'b0};
            if (bit_q != 3'h0)
               bit_q <= bit_q - 3'h1;
            else
            begin
               ack_phase_q <= 1'b1;
               tx_drive_q <= 1'b0;
               case (state_q)
                  CGI_ADDR:
                  begin
                     if (shift_q[7:1] == {cgi_pkg::DEV_ADDR_HI, sel_sync_q[1]})
                     begin
                        ack_drive_q <= 1'b1;
                        state_q <= (shift_q[0] == cgi_pkg::RW_READ) ? CGI_RDATA : CGI_INDEX;
                        tx_q <= mem[index_q];
                     end
                     else
                        state_q <= CGI_SKIP;
                  end
                  CGI_INDEX:
                  begin
                     ack_drive_q <= 1'b1;
                     index_q <= shift_q;
                     state_q <= CGI_WDATA;
                  end
                  CGI_WDATA:
                  begin
                     ack_drive_q <= 1'b1;
                     wr_strobe <= 1'b1;
                     wr_index <= index_q;
                     wr_data <= shift_q;
                     index_q <= next_index(index_q);
                  end
                  CGI_RDATA:
                  begin
                     index_q <= next_index(index_q);
                  end
                  default:
                     state_q <= CGI_SKIP;
               endcase
            end
         end
         else if (scl_fall && ack_phase_q)
         begin
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            bit_q <= cgi_pkg::BIT_MSB;
            if (state_q == CGI_RDATA)
            begin
               if (master_ack_q)
               begin
                  tx_q <= mem[index_q];
                  tx_drive_q <= 1'b1;
               end
               else
                  state_q <= CGI_SKIP;
            end
         end
         else if (state_q == CGI_RDATA && !ack_phase_q && bit_q == cgi_pkg::BIT_MSB && !tx_drive_q && !scl_q)
         begin
            tx_drive_q <= 1'b1;
            master_ack_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (wr_strobe)
         mem[wr_index] <= wr_data;
   end

   // The slave only ever pulls low; a one bit is released.
   assign link.sda_s_o = 1'b0;
   assign link.sda_s_oe_n = !((ack_drive_q) || (tx_drive_q && !tx_q[7]));
   assign cur_index = index_q;
   assign busy = (state_q != CGI_IDLE);
endmodule

// ==== rtl/cgi_master.sv ====
// Host end: two-wire bus master issuing one register read or write per command.
`timescale 1ns/1ps
module cgi_master #(
   parameter int QTR = cgi_pkg::SCL_QTR_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   cgi_link_if.master link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic target_select,
   input wire logic [7:0] cmd_index,
   input wire logic [7:0] cmd_wdata,
   output logic done,
   output logic nack,
   output logic [7:0] rdata
);
   typedef enum logic [2:0] {
      CGM_IDLE = 3'b000,
      CGM_START = 3'b001,
      CGM_BITS = 3'b011,
      CGM_RSTART = 3'b010,
      CGM_STOP = 3'b110
   } cgm_state_e;

   cgm_state_e state_q;
   logic [15:0] cnt_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic scl_q;
   logic sda_q;
   logic rd_q;
   logic sel_q;
   logic [7:0] idx_q;
   logic [7:0] wd_q;
   logic err_q;
   logic [1:0] sda_sync_q;
   logic tick;

   function automatic logic [7:0] addr_byte(input logic sel, input logic rw);
      addr_byte = {cgi_pkg::DEV_ADDR_HI, sel, rw};
   endfunction

   assign tick = (cnt_q == 16'(QTR - 1));

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sda_sync_q <= 2'h3;
      else
         sda_sync_q <= {sda_sync_q[0], link.sda};
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt_q <= 16'h0000;
      else if (state_q == CGM_IDLE || tick)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= CGM_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rd_q <= 1'b0;
         sel_q <= 1'b0;
         idx_q <= 8'h00;
         wd_q <= 8'h00;
         err_q <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         rdata <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         case (state_q)
            CGM_IDLE:
            begin
               if (cmd_valid)
               begin
                  rd_q <= cmd_read;
                  sel_q <= target_select;
                  idx_q <= cmd_index;
                  wd_q <= cmd_wdata;
                  tx_q <= addr_byte(target_select, cgi_pkg::RW_WRITE);
                  byte_q <= 2'h0;
                  err_q <= 1'b0;
                  ph_q <= 2'h0;
                  state_q <= CGM_START;
               end
            end
            CGM_START, CGM_RSTART:
            begin
               if (tick)
               begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0: begin sda_q <= 1'b1; scl_q <= 1'b1; end
                     2'h1: sda_q <= 1'b0;
                     2'h2: scl_q <= 1'b0;
                     default:
                     begin
                        bit_q <= 4'h0;
                        state_q <= CGM_BITS;
                     end
                  endcase
               end
            end
            CGM_BITS:
            begin
               if (tick)
               begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0:
                     begin
                        if (bit_q < 4'h8)
                           sda_q <= (rd_q && byte_q == 2'h3) ? 1'b1 : tx_q[7];
                        else
                           sda_q <= (rd_q && byte_q == 2'h3) ? cgi_pkg::NACK_LEVEL : 1'b1;
                     end
                     2'h1: scl_q <= 1'b1;
                     2'h2:
                     begin
                        if (bit_q < 4'h8)
                        begin
                           rx_q <= {rx_q[6:0], sda_sync_q[1]};
                           tx_q <= {tx_q[6:0], 1'b0};
                        end
                        else if (!(rd_q && byte_q == 2'h3) && sda_sync_q[1] != cgi_pkg::ACK_LEVEL)
                           err_q <= 1'b1;
                     end
                     default:
                     begin
                        scl_q <= 1'b0;
                        if (bit_q != 4'h8)
                           bit_q <= bit_q + 4'h1;
                        else
                        begin
                           bit_q <= 4'h0;
                           byte_q <= byte_q + 2'h1;
                           if (err_q)
                              state_q <= CGM_STOP;
                           else if (byte_q == 2'h0)
                              tx_q <= idx_q;
                           else if (byte_q == 2'h1 && !rd_q)
                              tx_q <= wd_q;
                           else if (byte_q == 2'h1)
                           begin
                              tx_q <= addr_byte(sel_q, cgi_pkg::RW_READ);
                              state_q <= CGM_RSTART;
                           end
                           // After the read address the data byte still follows.
                           else if (byte_q == 2'h2 && rd_q)
                              tx_q <= 8'hFF;
                           else
                           begin
                              if (rd_q)
                                 rdata <= rx_q;
                              state_q <= CGM_STOP;
                           end
                        end
                     end
                  endcase
               end
            end
            CGM_STOP:
            begin
               if (tick)
               begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0: sda_q <= 1'b0;
                     2'h1: scl_q <= 1'b1;
                     2'h2: sda_q <= 1'b1;
                     default:
                     begin
                        done <= 1'b1;
                        nack <= err_q;
                        state_q <= CGM_IDLE;
                     end
                  endcase
               end
            end
            default:
               state_q <= CGM_IDLE;
         endcase
      end
   end

   assign cmd_ready = (state_q == CGM_IDLE);
   assign link.scl_o = 1'b0;
   assign link.scl_oe_n = scl_q;
   assign link.sda_m_o = 1'b0;
   assign link.sda_m_oe_n = sda_q;
endmodule

// ==== test/cgi_checker.sv ====
// Assertions on the first two-wire link between master and register port.
`timescale 1ns/1ps
module cgi_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_oe_n,
   input wire logic address_select_pin
);
   logic scl_q, sda_q, hit_q, rd_q, rise, start, ack_due;
   logic [3:0] bit_q;
   logic [2:0] byte_q;
   logic [7:0] sh_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   assign rise = scl && !scl_q;
   assign start = scl && scl_q && sda_q && !sda;
   assign ack_due = (byte_q == 3'h0) ? (sh_q[7:1] == {cgi_pkg::DEV_ADDR_HI, address_select_pin}) : (hit_q && !rd_q);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // Bit and byte position within the current transaction, restarted by every start.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bit_q <= 4'h0;
         byte_q <= 3'h0;
         sh_q <= 8'h00;
      end
      else if (start)
      begin
         bit_q <= 4'h0;
         byte_q <= 3'h0;
      end
      else if (rise && bit_q == 4'h8)
      begin
         bit_q <= 4'h0;
         byte_q <= (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
      end
      else if (rise)
      begin
         bit_q <= bit_q + 4'h1;
         sh_q <= {sh_q[6:0], sda};
      end
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hit_q <= 1'b0;
         rd_q <= 1'b0;
      end
      else if (rise && bit_q == 4'h8 && byte_q == 3'h0)
      begin
         hit_q <= ack_due;
         rd_q <= sh_q[0];
      end
   end
   a_addr_ack_match: assert property (rise && bit_q == 4'h8 && byte_q == 3'h0 |-> sda == !ack_due)
      else $error("address acknowledge does not match the address");
   a_write_byte_ack: assert property (rise && bit_q == 4'h8 && byte_q != 3'h0 && hit_q && !rd_q |-> !sda)
      else $error("written byte not acknowledged");
   a_read_last_nack: assert property (rise && bit_q == 4'h8 && byte_q == 3'h1 && hit_q && rd_q |-> sda)
      else $error("single read byte was acknowledged");
   a_read_master_off: assert property (rise && bit_q < 4'h8 && byte_q == 3'h1 && hit_q && rd_q |-> sda_m_oe_n)
      else $error("master drives during read data");
   a_slave_silent_miss: assert property (byte_q != 3'h0 && !hit_q |-> sda_s_oe_n)
      else $error("slave drives after a foreign address");
   a_start_by_master: assert property (start |-> !sda_m_oe_n)
      else $error("start not made by the master");
   a_write_no_drive: assert property (rise && bit_q != 4'h8 && byte_q != 3'h0 && !rd_q |-> sda_s_oe_n)
      else $error("slave drives during written bits");
   a_ack_in_time: assert property ($fell(scl) && bit_q == 4'h8 && ack_due |-> ##[0:4] !sda_s_oe_n)
      else $error("acknowledge not driven in time");
   a_slave_moves_low: assert property ($changed(sda_s_oe_n) |-> !scl && !$past(scl))
      else $error("slave changed data while clock high");
endmodule

// ==== test/test_clock_gen_i2c_register_port.sv ====
// Bench: master and register port face each other; a second port is driven bit by bit.
`timescale 1ns/1ps
module test_clock_gen_i2c_register_port;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid = 1'b0, cmd_read = 1'b0, target_select = 1'b0, sel_pin = 1'b0;
   logic [7:0] cmd_index = 8'h00, cmd_wdata = 8'h00, rdata, wr_index, wr_data, wr_index2, wr_data2;
   logic cmd_ready, done, nack, wr_strobe, wr_strobe2, busy;
   logic [7:0] cur_index;
   logic [7:0] mem [256];
   logic [15:0] wr_notes [$];
   logic [17:0] done_notes [$];
   logic [15:0] wn;
   logic [17:0] dn;
   int num_errors = 0, samples_checked = 0, cycles = 0;
   cgi_link_if link ();
   cgi_link_if link2 ();
   cgi_master #(.QTR(5)) cgi_master_i (.clk(clk), .rstn(rstn), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_read(cmd_read), .target_select(target_select), .cmd_index(cmd_index),
      .cmd_wdata(cmd_wdata), .done(done), .nack(nack), .rdata(rdata));
   cgi_slave cgi_slave_i (.clk(clk), .rstn(rstn), .link(link), .address_select_pin(sel_pin),
      .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data), .cur_index(cur_index), .busy(busy));
   cgi_slave cgi_slave_far_i (.clk(clk), .rstn(rstn), .link(link2), .address_select_pin(1'b0),
      .wr_strobe(wr_strobe2), .wr_index(wr_index2), .wr_data(wr_data2), .cur_index(), .busy());
   cgi_checker cgi_checker_i (.clk(clk), .rstn(rstn), .scl(link.scl), .sda(link.sda),
      .sda_m_oe_n(link.sda_m_oe_n), .sda_s_oe_n(link.sda_s_oe_n), .address_select_pin(sel_pin));
   initial
   begin
      forever #25 clk = ~clk;
   end
   task automatic compare_value(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         num_errors++;
         report_and_stop;
      end
   end
   // Result watcher: every write strobe and every done pulse consumes the oldest note.
   always @(posedge clk)
   begin
      if (wr_strobe === 1'b1 || wr_strobe2 === 1'b1)
      begin
         wn = (wr_notes.size() > 0) ? wr_notes.pop_front() : 16'hXXXX;
         compare_value("write index", wn[15:8], wr_strobe ? wr_index : wr_index2);
         compare_value("write data", wn[7:0], wr_strobe ? wr_data : wr_data2);
      end
      if (done === 1'b1)
      begin
         dn = (done_notes.size() > 0) ? done_notes.pop_front() : 18'h3FFFF;
         compare_value("nack", {7'h00, dn[8]}, {7'h00, nack});
         if (dn[9])
            compare_value("read data", dn[7:0], rdata);
         if (!dn[8])
            compare_value("index after", dn[17:10], cur_index);
         compare_value("busy after stop", 8'h00, {7'h00, busy});
      end
   end
   task automatic run_cmd(input logic rd, input logic tsel, input logic [7:0] idx, input logic [7:0] dat);
      logic hit;
      hit = (tsel === sel_pin);
      done_notes.push_back({idx[7:4], idx[3:0] + 4'h1, rd && hit, !hit, rd ? mem[idx] : 8'h00});
      if (!rd && hit)
      begin
         wr_notes.push_back({idx, dat});
         mem[idx] = dat;
      end
      @(posedge clk);
      #2;
      cmd_read = rd;
      target_select = tsel;
      cmd_index = idx;
      cmd_wdata = dat;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      for (int n = 0; n < 4000 && done !== 1'b1; n++)
      begin
         @(posedge clk);
         #2;
      end
      compare_value("done", 8'h01, {7'h00, done});
   endtask
   // One quarter of a bench-made link clock period: 2 clk, 400 ns per bit.
   task automatic lines(input logic c, input logic d);
      link2.scl_oe_n = c;
      link2.sda_m_oe_n = d;
      repeat (2) @(posedge clk);
      #2;
   endtask
   task automatic bb_start;
      lines(1'b0, 1'b1);
      lines(1'b1, 1'b1);
      lines(1'b1, 1'b0);
      lines(1'b0, 1'b0);
   endtask
   task automatic bb_stop;
      lines(1'b0, 1'b0);
      lines(1'b1, 1'b0);
      lines(1'b1, 1'b1);
   endtask
   task automatic bb_byte(input logic [7:0] b, input logic ack_lvl, output logic [8:0] r);
      logic [8:0] v;
      v = {b, ack_lvl};
      for (int i = 8; i >= 0; i--)
      begin
         lines(1'b0, v[i]);
         lines(1'b1, v[i]);
         r[i] = link2.sda;
         lines(1'b1, v[i]);
         lines(1'b0, v[i]);
      end
   endtask
   // One write transaction of count bytes from index first, each byte noted for the watcher.
   task automatic bb_write_run(input logic [7:0] first, input int count);
      logic [8:0] r;
      logic [7:0] d;
      bb_start;
      bb_byte({cgi_pkg::DEV_ADDR_HI, 1'b0, cgi_pkg::RW_WRITE}, 1'b1, r);
      bb_byte(first, 1'b1, r);
      for (int k = 0; k < count; k++)
      begin
         d = 8'($urandom);
         wr_notes.push_back({first[7:4], first[3:0] + 4'(k), d});
         bb_byte(d, 1'b1, r);
         compare_value("group ack", 8'h00, {7'h00, r[0]});
      end
      bb_stop;
   endtask
   initial
   begin
      logic [8:0] r;
      logic [7:0] idx;
      logic [23:0] md;
      logic [3:0] lo;
      link2.scl_o = 1'b0;
      link2.sda_m_o = 1'b0;
      link2.scl_oe_n = 1'b1;
      link2.sda_m_oe_n = 1'b1;
      void'($urandom(44));
      repeat (16) @(posedge clk);
      #2;
      rstn = 1'b1;
      for (int s = 0; s < 2; s++)
      begin
         sel_pin = s[0];
         for (int k = 0; k < 5; k++)
         begin
            idx = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
            run_cmd(1'b0, sel_pin, idx, 8'($urandom));
            run_cmd(1'b1, sel_pin, idx, 8'h00);
         end
         run_cmd(1'b0, !sel_pin, idx, 8'h5A);
         run_cmd(1'b1, sel_pin, idx, 8'h00);
      end
      md = 24'($urandom);
      lo = 4'hE;
      bb_start;
      bb_byte({cgi_pkg::DEV_ADDR_HI, 1'b1, cgi_pkg::RW_WRITE}, 1'b1, r);
      compare_value("foreign ack", 8'h01, {7'h00, r[0]});
      bb_stop;
      bb_start;
      bb_byte({cgi_pkg::DEV_ADDR_HI, 1'b0, cgi_pkg::RW_WRITE}, 1'b1, r);
      compare_value("address ack", 8'h00, {7'h00, r[0]});
      bb_byte(8'h1E, 1'b1, r);
      compare_value("index ack", 8'h00, {7'h00, r[0]});
      for (int k = 0; k < 3; k++)
      begin
         wr_notes.push_back({4'h1, lo, md[k*8+:8]});
         lo = lo + 4'h1;
         bb_byte(md[k*8+:8], 1'b1, r);
         compare_value("data ack", 8'h00, {7'h00, r[0]});
      end
      bb_stop;
      bb_start;
      bb_byte({cgi_pkg::DEV_ADDR_HI, 1'b0, cgi_pkg::RW_WRITE}, 1'b1, r);
      bb_byte(8'h1E, 1'b1, r);
      bb_start;
      bb_byte({cgi_pkg::DEV_ADDR_HI, 1'b0, cgi_pkg::RW_READ}, 1'b1, r);
      compare_value("read address ack", 8'h00, {7'h00, r[0]});
      for (int k = 0; k < 3; k++)
      begin
         bb_byte(8'hFF, (k == 2) ? cgi_pkg::NACK_LEVEL : cgi_pkg::ACK_LEVEL, r);
         compare_value("far read", md[k*8+:8], r[8:1]);
      end
      bb_stop;
      bb_write_run(8'h00, 9);
      bb_write_run(8'h10, 3);
      repeat (20) @(posedge clk);
      report_and_stop;
   end
endmodule
